// >>> core/csbu_regs.svh
// Purpose: constants for the conditional skip and branch unit
// Assumes: 16-bit word program counter, 8-bit operands
// Notes: Function list follows
// Function
// [RULE1] skip_if_reg_bit_clear skips the next instruction when the chosen register bit is 0.
// [RULE2] skip_if_reg_bit_set skips the next instruction when the chosen register bit is 1.
// [RULE3] skip_if_io_bit_clear skips the next instruction when the chosen io bit is 0.
// [RULE4] skip_if_io_bit_set skips the next instruction when the chosen io bit is 1.
// [RULE5] branch_if_flag_set jumps to pc plus offset plus one when the chosen flag is 1.
// [RULE6] branch_if_flag_clear jumps to pc plus offset plus one when the chosen flag is 0.
// [RULE7] branch_if_equal jumps relative when the zero flag is 1.
// [RULE8] branch_if_not_equal jumps relative when the zero flag is 0.
// [RULE9] branch_if_carry_set and branch_if_lower jump relative when carry is 1.
// [RULE10] branch_if_carry_clear and branch_if_same_or_higher jump relative when carry is 0.
// [RULE11] no skip or branch ever changes the flag register.
// [RULE12] skips cost 1, 2 or 3 cycles and branches cost 1 or 2 cycles.
`ifndef CSBU_REGS_SVH
`define CSBU_REGS_SVH
`define CSBU_PC_W        16
`define CSBU_FLAG_CARRY  3'h0
`define CSBU_FLAG_ZERO   3'h1
`define CSBU_SKIP1_INC   16'h0002
`define CSBU_SKIP2_INC   16'h0003
`define CSBU_SEQ_INC     16'h0001
`define CSBU_CYC_ONE     2'h1
`define CSBU_CYC_TWO     2'h2
`define CSBU_CYC_THREE   2'h3
`endif

// >>> core/csbu_pkg.sv
// Purpose: types for the conditional skip and branch unit
// Assumes: nothing beyond the constants header
// Notes: operation codes are arbitrary internal encodings
package csbu_pkg;
  typedef enum logic [3:0] {
    CSBU_OP_NONE    = 4'h0,
    CSBU_OP_SKRC    = 4'h1, // skip_if_reg_bit_clear
    CSBU_OP_SKRS    = 4'h2, // skip_if_reg_bit_set
    CSBU_OP_SKIC    = 4'h3, // skip_if_io_bit_clear
    CSBU_OP_SKIS    = 4'h4, // skip_if_io_bit_set
    CSBU_OP_BFS     = 4'h5, // branch_if_flag_set
    CSBU_OP_BFC     = 4'h6, // branch_if_flag_clear
    CSBU_OP_BEQ     = 4'h7, // branch_if_equal
    CSBU_OP_BNE     = 4'h8, // branch_if_not_equal
    CSBU_OP_BCS     = 4'h9, // branch_if_carry_set
    CSBU_OP_BLO     = 4'ha, // branch_if_lower
    CSBU_OP_BCC     = 4'hb, // branch_if_carry_clear
    CSBU_OP_BSH     = 4'hc  // branch_if_same_or_higher
  } csbu_op_type;

  typedef enum logic [1:0] {
    CSBU_ST_IDLE = 2'h0,
    CSBU_ST_BUSY = 2'h1
  } csbu_state_type;

  typedef struct packed {
    csbu_state_type state;
    logic [1:0]     cyc_left;
    logic [15:0]    pc;
    logic           done;
    logic           taken;
    logic [1:0]     cycles;
  } csbu_core_type;
endpackage

// >>> core/csbu_cond_if.sv
// Purpose: carries a decoded condition test between the unit's modules
// Assumes: single clock domain
// Notes: combinational path only
`timescale 1ns/1ps
`default_nettype none
interface csbu_cond_if;
  import csbu_pkg::*;
  csbu_op_type op;
  logic [7:0]  reg_val;
  logic [7:0]  io_val;
  logic [7:0]  flags;
  logic [2:0]  bit_sel;
  logic        is_skip;
  logic        is_branch;
  logic        cond;
  modport eval (input op, reg_val, io_val, flags, bit_sel,
                output is_skip, is_branch, cond);
  modport ctrl (output op, reg_val, io_val, flags, bit_sel,
                input is_skip, is_branch, cond);
endinterface
`default_nettype wire

// >>> core/csbu_cond.sv
// Purpose: evaluates the condition of a skip or branch operation
// Assumes: operands stable while the operation is presented
// Notes: purely combinational, reads register, io and flag bytes
`timescale 1ns/1ps
`default_nettype none
`include "csbu_regs.svh"
module csbu_cond
  import csbu_pkg::*;
(
  csbu_cond_if.eval c
);
  // select one bit of a byte
  function automatic logic pick(input logic [7:0] v, input logic [2:0] s);
    pick = v[s];
  endfunction

  // condition per operation
  always_comb
  begin
    c.is_skip   = 1'b0;
    c.is_branch = 1'b1;
    c.cond      = 1'b0;
    case (c.op)
      CSBU_OP_SKRC:
      begin
        c.is_skip = 1'b1; c.is_branch = 1'b0;
        c.cond = !pick(c.reg_val, c.bit_sel); // RULE1
      end
      CSBU_OP_SKRS:
      begin
        c.is_skip = 1'b1; c.is_branch = 1'b0;
        c.cond = pick(c.reg_val, c.bit_sel); // RULE2
      end
      CSBU_OP_SKIC:
      begin
        c.is_skip = 1'b1; c.is_branch = 1'b0;
        c.cond = !pick(c.io_val, c.bit_sel); // RULE3
      end
      CSBU_OP_SKIS:
      begin
        c.is_skip = 1'b1; c.is_branch = 1'b0;
        c.cond = pick(c.io_val, c.bit_sel); // RULE4
      end
      CSBU_OP_BFS: c.cond = pick(c.flags, c.bit_sel);  // RULE5
      CSBU_OP_BFC: c.cond = !pick(c.flags, c.bit_sel); // RULE6
      CSBU_OP_BEQ: c.cond = pick(c.flags, `CSBU_FLAG_ZERO); // RULE7
      CSBU_OP_BNE: c.cond = !pick(c.flags, `CSBU_FLAG_ZERO); // RULE8
      CSBU_OP_BCS, CSBU_OP_BLO: c.cond = pick(c.flags, `CSBU_FLAG_CARRY); // RULE9
      CSBU_OP_BCC, CSBU_OP_BSH: c.cond = !pick(c.flags, `CSBU_FLAG_CARRY); // RULE10
      default: c.is_branch = 1'b0;
    endcase
  end
endmodule // csbu_cond
`default_nettype wire

// >>> core/csbu_top.sv
// Purpose: conditional skip and relative branch unit of the core
// Assumes: one operation presented per start pulse while idle
// Notes: result pc and cycle count appear the cycle after start; a one-cycle done pulse marks the last execution cycle
`timescale 1ns/1ps
`default_nettype none
`include "csbu_regs.svh"
module csbu_top
  import csbu_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  input  wire logic        i_START,
  input  wire csbu_op_type i_OP,
  input  wire logic [15:0] i_PC,
  input  wire logic [7:0]  i_REG_VAL,
  input  wire logic [7:0]  i_IO_VAL,
  input  wire logic [7:0]  i_FLAGS,
  input  wire logic [2:0]  i_BIT_SEL,
  input  wire logic [6:0]  i_OFFSET,
  input  wire logic        i_NEXT_TWO_WORD,
  output logic             o_BUSY,
  output logic             o_DONE,
  output logic             o_TAKEN,
  output logic [15:0]      o_NEXT_PC,
  output logic [1:0]       o_CYCLES,
  output logic [7:0]       o_FLAGS_OUT
);
  csbu_core_type cur_r;
  csbu_core_type cur_nxt;
  csbu_cond_if   cif ();

  // sign-extend the 7-bit branch offset
  function automatic logic [15:0] sext(input logic [6:0] k);
    sext = {{9{k[6]}}, k};
  endfunction

  // ----------------------------------------------------------------
  // condition evaluation
  // ----------------------------------------------------------------
  assign cif.op      = i_OP;
  assign cif.reg_val = i_REG_VAL;
  assign cif.io_val  = i_IO_VAL;
  assign cif.flags   = i_FLAGS;
  assign cif.bit_sel = i_BIT_SEL;

  csbu_cond u_cond (
    .c (cif.eval)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    cur_nxt      = cur_r;
    cur_nxt.done = 1'b0;
    case (cur_r.state)
      CSBU_ST_IDLE:
      begin
        if (i_START && (cif.is_skip || cif.is_branch))
        begin
          cur_nxt.taken = cif.cond;
          if (cif.is_skip && cif.cond)
          begin
            // skip over one or two words
            cur_nxt.pc = i_PC + (i_NEXT_TWO_WORD ? `CSBU_SKIP2_INC
                                                 : `CSBU_SKIP1_INC); // RULE1 RULE2 RULE3 RULE4
            cur_nxt.cycles = i_NEXT_TWO_WORD ? `CSBU_CYC_THREE
                                             : `CSBU_CYC_TWO; // RULE12
          end
          else if (cif.is_branch && cif.cond)
          begin
            cur_nxt.pc = i_PC + sext(i_OFFSET) + `CSBU_SEQ_INC; // RULE5 RULE6 RULE7 RULE8 RULE9 RULE10
            cur_nxt.cycles = `CSBU_CYC_TWO; // RULE12
          end
          else
          begin
            cur_nxt.pc = i_PC + `CSBU_SEQ_INC;
            cur_nxt.cycles = `CSBU_CYC_ONE; // RULE12
          end
          cur_nxt.cyc_left = cur_nxt.cycles - 2'h1;
          if (cur_nxt.cyc_left == 2'h0)
            cur_nxt.done = 1'b1;
          else
            cur_nxt.state = CSBU_ST_BUSY;
        end
      end
      CSBU_ST_BUSY:
      begin
        // hold for the remaining execution cycles
        cur_nxt.cyc_left = cur_r.cyc_left - 2'h1;
        if (cur_r.cyc_left == 2'h1)
        begin
          cur_nxt.done  = 1'b1;
          cur_nxt.state = CSBU_ST_IDLE;
        end
      end
      default: cur_nxt.state = CSBU_ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
      cur_r <= '{state: CSBU_ST_IDLE, cyc_left: 2'h0, pc: 16'h0000,
                 done: 1'b0, taken: 1'b0, cycles: 2'h0};
    else
      cur_r <= cur_nxt;
  end

  // outputs
  assign o_BUSY      = (cur_r.state == CSBU_ST_BUSY);
  assign o_DONE      = cur_r.done;
  assign o_TAKEN     = cur_r.taken;
  assign o_NEXT_PC   = cur_r.pc;
  assign o_CYCLES    = cur_r.cycles;
  assign o_FLAGS_OUT = i_FLAGS; // RULE11

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_skip_reg_clear;
    @(posedge I_CLK) disable iff (I_RST)
    (!o_BUSY && i_START && i_OP == CSBU_OP_SKRC && !i_REG_VAL[i_BIT_SEL])
      |=> o_TAKEN && o_CYCLES != `CSBU_CYC_ONE;
  endproperty
  a_skip_reg_clear: assert property (p_skip_reg_clear) else $error("reg clear skip missed"); // RULE1

  property p_skip_reg_set;
    @(posedge I_CLK) disable iff (I_RST)
    (!o_BUSY && i_START && i_OP == CSBU_OP_SKRS && !i_NEXT_TWO_WORD)
      |=> o_NEXT_PC == $past(i_PC) + ($past(i_REG_VAL[i_BIT_SEL]) ? 16'h0002 : 16'h0001);
  endproperty
  a_skip_reg_set: assert property (p_skip_reg_set) else $error("reg set skip pc wrong"); // RULE2

  property p_skip_io_clear;
    @(posedge I_CLK) disable iff (I_RST)
    (!o_BUSY && i_START && i_OP == CSBU_OP_SKIC && !i_IO_VAL[i_BIT_SEL] && i_NEXT_TWO_WORD)
      |=> o_NEXT_PC == $past(i_PC) + 16'h0003 ##1 o_BUSY ##1 o_DONE;
  endproperty
  a_skip_io_clear: assert property (p_skip_io_clear) else $error("io clear skip wrong"); // RULE3

  property p_skip_io_set;
    @(posedge I_CLK) disable iff (I_RST)
    (!o_BUSY && i_START && i_OP == CSBU_OP_SKIS) |=> o_TAKEN == $past(i_IO_VAL[i_BIT_SEL]);
  endproperty
  a_skip_io_set: assert property (p_skip_io_set) else $error("io set skip wrong"); // RULE4

  property p_br_flag_set;
    @(posedge I_CLK) disable iff (I_RST)
    (!o_BUSY && i_START && i_OP == CSBU_OP_BFS && i_FLAGS[i_BIT_SEL])
      |=> o_NEXT_PC == $past(i_PC) + {{9{$past(i_OFFSET[6])}}, $past(i_OFFSET)} + 16'h0001;
  endproperty
  a_br_flag_set: assert property (p_br_flag_set) else $error("flag set branch wrong"); // RULE5

  property p_br_flag_clear;
    @(posedge I_CLK) disable iff (I_RST)
    (!o_BUSY && i_START && i_OP == CSBU_OP_BFC) |=> o_TAKEN == !$past(i_FLAGS[i_BIT_SEL]);
  endproperty
  a_br_flag_clear: assert property (p_br_flag_clear) else $error("flag clear branch wrong"); // RULE6

  property p_br_eq;
    @(posedge I_CLK) disable iff (I_RST)
    (!o_BUSY && i_START && i_OP == CSBU_OP_BEQ) |=> o_TAKEN == $past(i_FLAGS[1]);
  endproperty
  a_br_eq: assert property (p_br_eq) else $error("equal branch wrong"); // RULE7

  property p_br_ne;
    @(posedge I_CLK) disable iff (I_RST)
    (!o_BUSY && i_START && i_OP == CSBU_OP_BNE && i_FLAGS[1]) |=> !o_TAKEN && o_DONE;
  endproperty
  a_br_ne: assert property (p_br_ne) else $error("not equal branch wrong"); // RULE8

  property p_br_carry;
    @(posedge I_CLK) disable iff (I_RST)
    (!o_BUSY && i_START && (i_OP == CSBU_OP_BCS || i_OP == CSBU_OP_BLO))
      |=> o_TAKEN == $past(i_FLAGS[0]);
  endproperty
  a_br_carry: assert property (p_br_carry) else $error("carry set branch wrong"); // RULE9

  property p_br_nocarry;
    @(posedge I_CLK) disable iff (I_RST)
    (!o_BUSY && i_START && (i_OP == CSBU_OP_BCC || i_OP == CSBU_OP_BSH))
      |=> o_TAKEN == !$past(i_FLAGS[0]);
  endproperty
  a_br_nocarry: assert property (p_br_nocarry) else $error("carry clear branch wrong"); // RULE10

  property p_flags_kept;
    @(posedge I_CLK) disable iff (I_RST)
    o_FLAGS_OUT == i_FLAGS;
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flags modified"); // RULE11

  property p_taken_branch_two;
    @(posedge I_CLK) disable iff (I_RST)
    (!o_BUSY && i_START && i_OP == CSBU_OP_BEQ && i_FLAGS[1])
      |=> o_BUSY && !o_DONE ##1 o_DONE && !o_BUSY;
  endproperty
  a_taken_branch_two: assert property (p_taken_branch_two) else $error("branch timing wrong"); // RULE12

  // untaken flag branch falls through in one cycle
  property p_fall_thru;
    @(posedge I_CLK) disable iff (I_RST)
    (!o_BUSY && i_START && i_OP == CSBU_OP_BFS && !i_FLAGS[i_BIT_SEL])
      |=> o_NEXT_PC == $past(i_PC) + `CSBU_SEQ_INC && o_DONE && o_CYCLES == `CSBU_CYC_ONE;
  endproperty
  a_fall_thru: assert property (p_fall_thru) else $error("fall through wrong"); // RULE12

  // skip over a one-word instruction costs two cycles
  property p_skip_one;
    @(posedge I_CLK) disable iff (I_RST)
    (!o_BUSY && i_START && i_OP == CSBU_OP_SKRC && !i_REG_VAL[i_BIT_SEL] && !i_NEXT_TWO_WORD)
      |=> o_BUSY && o_CYCLES == `CSBU_CYC_TWO ##1 o_DONE && !o_BUSY;
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("one word skip timing wrong"); // RULE12

  // a start while busy leaves the result alone
  property p_busy_hold;
    @(posedge I_CLK) disable iff (I_RST)
    (o_BUSY && i_START) |=> $stable(o_NEXT_PC) && $stable(o_CYCLES);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("start while busy accepted"); // RULE12

  // the empty operation is ignored
  property p_none_ignored;
    @(posedge I_CLK) disable iff (I_RST)
    (!o_BUSY && i_START && i_OP == CSBU_OP_NONE) |=> !o_DONE && !o_BUSY && $stable(o_NEXT_PC);
  endproperty
  a_none_ignored: assert property (p_none_ignored) else $error("empty operation accepted"); // RULE12

  c_skip3: cover property (@(posedge I_CLK) o_DONE && o_CYCLES == 2'h3);
  c_skip2: cover property (@(posedge I_CLK) o_DONE && o_CYCLES == 2'h2 && o_TAKEN);
  c_nottaken: cover property (@(posedge I_CLK) o_DONE && !o_TAKEN);
  c_busy_start: cover property (@(posedge I_CLK) o_BUSY && i_START);
endmodule // csbu_top
`default_nettype wire

// >>> tb/csbu_tb.sv
// Purpose: self-checking bench for the skip and branch unit
// Assumes: csbu_pkg and the unit's files compiled first
// Notes: each scenario task drives operations and judges results
`timescale 1ns/1ps
`default_nettype none
module tb
  import csbu_pkg::*;
;
  logic        I_CLK;
  logic        I_RST;
  logic        i_start;
  csbu_op_type i_op;
  logic [15:0] i_pc;
  logic [7:0]  i_reg;
  logic [7:0]  i_io;
  logic [7:0]  i_flags;
  logic [2:0]  i_bit;
  logic [6:0]  i_off;
  logic        i_two;
  logic        o_busy;
  logic        o_done;
  logic        o_taken;
  logic [15:0] o_pc;
  logic [1:0]  o_cyc;
  logic [7:0]  o_flags;
  int          n_errors = 0;
  int          compares = 0;
  int          cyc_cnt  = 0;

  csbu_top i_csbu_top (.I_CLK(I_CLK), .I_RST(I_RST), .i_START(i_start), .i_OP(i_op),
    .i_PC(i_pc), .i_REG_VAL(i_reg), .i_IO_VAL(i_io), .i_FLAGS(i_flags),
    .i_BIT_SEL(i_bit), .i_OFFSET(i_off), .i_NEXT_TWO_WORD(i_two), .o_BUSY(o_busy),
    .o_DONE(o_done), .o_TAKEN(o_taken), .o_NEXT_PC(o_pc), .o_CYCLES(o_cyc),
    .o_FLAGS_OUT(o_flags));

  // -----------------------------------------------------------
  // clock, timeout and closing report
  // -----------------------------------------------------------
  initial
  begin
    I_CLK = 1'b0;
    forever #20 I_CLK = ~I_CLK;
  end

  // hang guard
  always @(posedge I_CLK)
  begin
    cyc_cnt++;
    if (cyc_cnt == 3000)
    begin
      n_errors++;
      $display("Error timeout expected done seen hang");
      end_sim();
    end
  end

  task automatic end_sim();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // -----------------------------------------------------------
  // one operation: drive, predict, compare
  // -----------------------------------------------------------
  task automatic run_op(input csbu_op_type op, input logic [7:0] rv, input logic [7:0] iv,
    input logic [7:0] fl, input logic [2:0] b, input logic [6:0] k, input logic two);
    logic        cond;
    logic [15:0] pc;
    logic [15:0] epc;
    logic [1:0]  ecyc;
    int          n;
    pc = {fl ^ 8'hf0, rv};
    case (op)
      CSBU_OP_SKRC: cond = !rv[b];
      CSBU_OP_SKRS: cond = rv[b];
      CSBU_OP_SKIC: cond = !iv[b];
      CSBU_OP_SKIS: cond = iv[b];
      CSBU_OP_BFS:  cond = fl[b];
      CSBU_OP_BFC:  cond = !fl[b];
      CSBU_OP_BEQ:  cond = fl[1];
      CSBU_OP_BNE:  cond = !fl[1];
      CSBU_OP_BCS,
      CSBU_OP_BLO:  cond = fl[0];
      default:      cond = !fl[0];
    endcase
    epc  = pc + 16'h0001;
    ecyc = 2'h1;
    if (cond && op inside {[CSBU_OP_SKRC:CSBU_OP_SKIS]})
    begin
      epc  = pc + (two ? 16'h0003 : 16'h0002);
      ecyc = two ? 2'h3 : 2'h2;
    end
    else if (cond)
    begin
      epc  = pc + {{9{k[6]}}, k} + 16'h0001;
      ecyc = 2'h2;
    end
    @(posedge I_CLK);
    i_start <= 1'b1;
    i_op    <= op;
    i_pc    <= pc;
    i_reg   <= rv;
    i_io    <= iv;
    i_flags <= fl;
    i_bit   <= b;
    i_off   <= k;
    i_two   <= two;
    @(posedge I_CLK);
    i_start <= 1'b0;
    #1;
    check("next_pc", o_pc, epc);
    check("taken", {15'h0000, o_taken}, {15'h0000, cond});
    check("cycles", {14'h0000, o_cyc}, {14'h0000, ecyc});
    check("flags_out", {8'h00, o_flags}, {8'h00, fl});
    check("busy", {15'h0000, o_busy}, {15'h0000, ecyc != 2'h1});
    n = 1;
    while (o_done !== 1'b1 && n < 5)
    begin
      @(posedge I_CLK);
      #1;
      n++;
    end
    check("done_delay", 16'(n), {14'h0000, ecyc});
  endtask

  // -----------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------
  task automatic test_skips();
    logic [7:0] p;
    for (int b = 0; b < 8; b++)
      for (int v = 0; v < 2; v++)
      begin
        p = (v != 0) ? (8'h01 << b) : ~(8'h01 << b);
        run_op(CSBU_OP_SKRC, p, ~p, 8'h00, 3'(b), 7'h00, b[0]);
        run_op(CSBU_OP_SKRS, p, ~p, 8'hff, 3'(b), 7'h00, b[1]);
        run_op(CSBU_OP_SKIC, ~p, p, 8'h00, 3'(b), 7'h00, b[1]);
        run_op(CSBU_OP_SKIS, ~p, p, 8'hff, 3'(b), 7'h00, b[0]);
      end
    $display("test skips finished");
  endtask

  task automatic test_flag_branch();
    logic [7:0] f;
    for (int b = 0; b < 8; b++)
      for (int v = 0; v < 2; v++)
      begin
        f = (v != 0) ? (8'h01 << b) : ~(8'h01 << b);
        run_op(CSBU_OP_BFS, 8'h5a, 8'ha5, f, 3'(b), 7'h40, 1'b1);
        run_op(CSBU_OP_BFC, 8'h5a, 8'ha5, f, 3'(b), 7'h3f, 1'b0);
      end
    $display("test flag branch finished");
  endtask

  task automatic test_zero_carry();
    logic [7:0] f;
    for (int v = 0; v < 4; v++)
    begin
      f = {6'h2a, 2'(v)};
      run_op(CSBU_OP_BEQ, 8'h11, 8'h22, f, 3'h7, 7'h7f, 1'b1);
      run_op(CSBU_OP_BNE, 8'h11, 8'h22, f, 3'h6, 7'h01, 1'b1);
      run_op(CSBU_OP_BCS, 8'h33, 8'h44, f, 3'h5, 7'h70, 1'b0);
      run_op(CSBU_OP_BLO, 8'h33, 8'h44, f, 3'h4, 7'h0f, 1'b0);
      run_op(CSBU_OP_BCC, 8'h55, 8'h66, f, 3'h3, 7'h41, 1'b1);
      run_op(CSBU_OP_BSH, 8'h55, 8'h66, f, 3'h2, 7'h3e, 1'b1);
    end
    $display("test zero carry finished");
  endtask

  // second start while busy must leave the skip result alone
  task automatic test_busy_refuse();
    run_op(CSBU_OP_SKRS, 8'h02, 8'h00, 8'h00, 3'h1, 7'h00, 1'b1);
    @(posedge I_CLK);
    i_start <= 1'b1;
    i_op    <= CSBU_OP_SKRS;
    i_pc    <= 16'h1000;
    @(posedge I_CLK);
    i_op    <= CSBU_OP_BEQ;
    i_flags <= 8'h02;
    i_off   <= 7'h05;
    @(posedge I_CLK);
    i_start <= 1'b0;
    #1;
    check("busy_pc", o_pc, 16'h1003);
    check("busy_cycles", {14'h0000, o_cyc}, 16'h0003);
    repeat (3) @(posedge I_CLK);
    #1;
    check("after_pc", o_pc, 16'h1003);
    $display("test busy refuse finished");
  endtask

  // empty operation ignored, then a new start in the done cycle
  task automatic test_none_back();
    run_op(CSBU_OP_BNE, 8'h00, 8'h00, 8'h02, 3'h0, 7'h00, 1'b0);
    @(posedge I_CLK);
    i_start <= 1'b1;
    i_op    <= CSBU_OP_NONE;
    i_pc    <= 16'h2000;
    @(posedge I_CLK);
    i_start <= 1'b0;
    #1;
    check("none_done", {15'h0000, o_done}, 16'h0000);
    check("none_pc", o_pc, 16'hf201);
    @(posedge I_CLK);
    i_start <= 1'b1;
    i_op    <= CSBU_OP_BEQ;
    i_flags <= 8'h00;
    i_pc    <= 16'h3000;
    @(posedge I_CLK);
    i_op    <= CSBU_OP_BCC;
    i_off   <= 7'h10;
    i_pc    <= 16'h4000;
    #1;
    check("b2b_first_done", {15'h0000, o_done}, 16'h0001);
    check("b2b_first_pc", o_pc, 16'h3001);
    @(posedge I_CLK);
    i_start <= 1'b0;
    #1;
    check("b2b_second_pc", o_pc, 16'h4011);
    check("b2b_second_busy", {15'h0000, o_busy}, 16'h0001);
    @(posedge I_CLK);
    #1;
    check("b2b_second_done", {15'h0000, o_done}, 16'h0001);
    $display("test none back finished");
  endtask

  // -----------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------
  initial
  begin
    I_RST   = 1'b1;
    i_start = 1'b0;
    i_op    = CSBU_OP_NONE;
    i_pc    = 16'h0000;
    i_reg   = 8'h00;
    i_io    = 8'h00;
    i_flags = 8'h00;
    i_bit   = 3'h0;
    i_off   = 7'h00;
    i_two   = 1'b0;
    repeat (6) @(posedge I_CLK);
    I_RST <= 1'b0;
    test_skips();
    test_flag_branch();
    test_zero_carry();
    test_busy_refuse();
    test_none_back();
    end_sim();
  end
endmodule // tb
`default_nettype wire
